// ===== hw/bfdsg_core.sv
// fast-deceleration duty shaper and stall/fault guard
// assumes duty/speed/current inputs come from logic on clk_in; update_in is a 1-cycle pulse
`timescale 1ns/1ps
`include "bfdsg_defs.svh"
module bfdsg_core (
  input  wire logic                       clk_in,
  input  wire logic                       rst_n_in,
  input  wire logic                       update_in,
  input  wire logic [`BFDSG_DUTY_W-1:0]   duty_cmd_in,
  input  wire logic [`BFDSG_DUTY_W-1:0]   duty_now_in,
  input  wire logic [`BFDSG_SPD_W-1:0]    speed_in,
  input  wire logic [`BFDSG_SPD_W-1:0]    speed_max_in,
  input  wire logic [`BFDSG_CUR_W-1:0]    phase_current_in,
  input  wire logic                       fast_decel_enable_in,
  input  wire logic [`BFDSG_CUR_W-1:0]    quick_slowdown_current_cap_in,
  input  wire logic                       anti_surge_enable_in,
  input  wire logic [`BFDSG_DUTY_W-1:0]   slowdown_stop_margin_in,
  input  wire logic                       speed_scaled_brake_current_enable_in,
  input  wire logic [`BFDSG_CUR_W-1:0]    zero_speed_brake_current_in,
  input  wire logic [`BFDSG_DUTY_W-1:0]   slowdown_duty_threshold_in,
  input  wire logic [`BFDSG_DUTY_W-1:0]   slowdown_min_window_in,
  input  wire logic                       comparator_blanking_enable_in,
  input  wire bfdsg_pkg::bfdsg_stop_t     stop_method_select_in,
  input  wire logic                       stop_request_in,
  input  wire logic [`BFDSG_CUR_W-1:0]    lock_current_threshold_in,
  input  wire logic [`BFDSG_CNT_W-1:0]    lock_current_deglitch_in,
  input  wire bfdsg_pkg::bfdsg_lock_mode_t lock_fault_handling_mode_in,
  input  wire logic [`BFDSG_RETRY_W-1:0]  retry_count_in,
  input  wire logic [`BFDSG_CNT_W-1:0]    retry_interval_in,
  input  wire logic                       demag_sel_we_in,
  input  wire logic [`BFDSG_DEMAG_W-1:0]  demag_sel_in,
  input  wire logic                       cycle_limit_event_in,
  input  wire logic                       sync_lost_event_in,
  input  wire logic [`BFDSG_SPD_W-1:0]    overspeed_threshold_in,
  input  wire logic                       fault_clear_in,
  output logic                            fast_decel_active_out,
  output logic                            anti_surge_active_out,
  output logic [`BFDSG_CUR_W-1:0]         brake_current_limit_out,
  output logic                            current_clamp_out,
  output logic                            comparator_blanking_out,
  output logic                            recirc_brake_out,
  output logic [`BFDSG_DEMAG_W-1:0]       demagnetize_window_max_out,
  output logic                            drive_enable_out,
  output logic                            restart_out,
  output logic                            lock_current_fault_out,
  output logic                            cycle_current_limit_fault_out,
  output logic                            rotor_locked_fault_out,
  output logic                            sync_lost_fault_out,
  output logic                            overspeed_fault_out
);
  import bfdsg_pkg::*;

  typedef struct packed {
    logic [`BFDSG_DUTY_W-1:0]  start_duty;
    logic                      in_decel;
    logic                      fast;
    logic                      surge;
    logic [`BFDSG_CUR_W-1:0]   cur_lim;
    logic                      clamp;
    logic                      blank;
    logic                      recirc;
    logic [`BFDSG_CNT_W-1:0]   recirc_cnt;
    logic [`BFDSG_DEMAG_W-1:0] demag;
    bfdsg_lock_state_t         lk_st;
    logic [`BFDSG_CNT_W-1:0]   lk_cnt;
    logic [`BFDSG_RETRY_W-1:0] tries;
    logic                      drive;
    logic                      restart;
    logic                      f_lock;
    logic                      f_cbc;
    logic                      f_rotor;
    logic                      f_sync;
    logic                      f_ovs;
  } bfdsg_core_t;

  bfdsg_core_t s_r;
  bfdsg_core_t s_nxt;
  logic        lock_hit;
  logic        over_lock;

  // spans and thresholds, widened by one bit so the margin sum cannot overflow
  logic [`BFDSG_DUTY_W:0] span;
  logic [`BFDSG_DUTY_W:0] stop_point;
  logic [`BFDSG_DUTY_W:0] late_start;
  logic                   start_hi;
  logic                   gate_ok;
  logic [`BFDSG_CUR_W+`BFDSG_SPD_W-1:0] scaled;
  logic [`BFDSG_CUR_W-1:0] dyn_lim;

  assign over_lock = phase_current_in > lock_current_threshold_in;

  bfdsg_deglitch u_lock_dg (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .level_in (over_lock && s_r.drive),
    .count_in (lock_current_deglitch_in),
    .hit_out  (lock_hit)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // fast-deceleration gating

  always_comb begin
    span       = {1'b0, s_r.start_duty} - {1'b0, duty_cmd_in};
    stop_point = {1'b0, duty_cmd_in} + {1'b0, slowdown_stop_margin_in};
    late_start = {1'b0, slowdown_duty_threshold_in} - {1'b0, slowdown_min_window_in};
    start_hi   = s_r.start_duty >= slowdown_duty_threshold_in;
    gate_ok    = (span >= {1'b0, slowdown_min_window_in})
                 && ({1'b0, duty_now_in} > stop_point)
                 && (duty_now_in < slowdown_duty_threshold_in)
                 && (!start_hi || ({1'b0, duty_now_in} < late_start));
    // linear taper from the full cap at max speed down to the zero-speed cap
    scaled = (speed_max_in == '0) ? '0 :
             (`BFDSG_CUR_W+`BFDSG_SPD_W)'(({`BFDSG_SPD_W'(0), quick_slowdown_current_cap_in}
               * {`BFDSG_CUR_W'(0), (speed_in > speed_max_in ? speed_max_in : speed_in)})
               / {`BFDSG_CUR_W'(0), speed_max_in});
    if (scaled[`BFDSG_CUR_W-1:0] < zero_speed_brake_current_in) begin
      dyn_lim = zero_speed_brake_current_in;
    end else begin
      dyn_lim = scaled[`BFDSG_CUR_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    s_nxt         = s_r;
    s_nxt.restart = 1'b0;

    // decel tracking: latch the duty at which the command first dropped
    if (update_in) begin
      if (duty_cmd_in < duty_now_in) begin
        if (!s_r.in_decel) begin
          s_nxt.start_duty = duty_now_in;
          s_nxt.in_decel   = 1'b1;
        end
      end else begin
        s_nxt.in_decel = 1'b0;
      end
      s_nxt.fast  = fast_decel_enable_in && s_r.in_decel && gate_ok;
      // anti-surge covers every deceleration; above the threshold it runs alone
      s_nxt.surge = anti_surge_enable_in && (duty_cmd_in < duty_now_in);
    end
    if (!s_r.in_decel || !fast_decel_enable_in) begin
      s_nxt.fast = 1'b0;
    end

    // while anti-surge is on the current cap is dropped to a quarter: slower decel
    s_nxt.cur_lim = speed_scaled_brake_current_enable_in ? dyn_lim
                    : quick_slowdown_current_cap_in;
    if (s_r.surge) begin
      s_nxt.cur_lim = s_nxt.cur_lim >> `BFDSG_SURGE_DIV;
    end
    s_nxt.clamp = s_r.fast && (phase_current_in >= s_r.cur_lim);
    s_nxt.blank = comparator_blanking_enable_in;

    // recirculation stop: auto-configured hold time, no energy pumped back to supply
    if (stop_request_in && stop_method_select_in == BFDSG_STOP_RECIRC && !s_r.recirc) begin
      s_nxt.recirc     = 1'b1;
      s_nxt.recirc_cnt = `BFDSG_CNT_W'(`BFDSG_RECIR_CYC);
    end else if (s_r.recirc) begin
      if (s_r.recirc_cnt == '0) begin
        s_nxt.recirc = 1'b0;
      end else begin
        s_nxt.recirc_cnt = s_r.recirc_cnt - `BFDSG_CNT_W'(1);
      end
    end

    if (demag_sel_we_in) begin
      s_nxt.demag = demag_sel_in;
    end

    // sticky faults: a new event wins over a clear in the same cycle
    if (fault_clear_in) begin
      s_nxt.f_cbc   = 1'b0;
      s_nxt.f_rotor = 1'b0;
      s_nxt.f_sync  = 1'b0;
      s_nxt.f_ovs   = 1'b0;
    end
    if (cycle_limit_event_in) begin
      s_nxt.f_cbc = 1'b1;
    end
    if (sync_lost_event_in) begin
      s_nxt.f_sync = 1'b1;
    end
    if (speed_in > overspeed_threshold_in) begin
      s_nxt.f_ovs = 1'b1;
    end

    // lock handling
    unique case (s_r.lk_st)
      BFDSG_RUN: begin
        if (fault_clear_in) begin
          s_nxt.f_lock = 1'b0;
          s_nxt.tries  = '0;
        end
        if (lock_hit) begin
          s_nxt.f_lock  = 1'b1;
          s_nxt.f_rotor = 1'b1;
          s_nxt.drive   = 1'b0;
          if (lock_fault_handling_mode_in == BFDSG_LOCK_RETRY
              && s_r.tries < retry_count_in) begin
            s_nxt.lk_st  = BFDSG_WAIT;
            s_nxt.lk_cnt = retry_interval_in;
          end else begin
            s_nxt.lk_st = BFDSG_LOCKED;
          end
        end
      end
      BFDSG_LOCKED: begin
        if (fault_clear_in) begin
          s_nxt.f_lock = 1'b0;
          s_nxt.tries  = '0;
          s_nxt.drive  = 1'b1;
          s_nxt.lk_st  = BFDSG_RUN;
        end
      end
      BFDSG_WAIT: begin
        if (s_r.lk_cnt == '0) begin
          s_nxt.tries   = s_r.tries + `BFDSG_RETRY_W'(1);
          s_nxt.f_lock  = 1'b0;
          s_nxt.f_rotor = 1'b0;
          s_nxt.drive   = 1'b1;
          s_nxt.restart = 1'b1;
          s_nxt.lk_st   = BFDSG_RUN;
        end else begin
          s_nxt.lk_cnt = s_r.lk_cnt - `BFDSG_CNT_W'(1);
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      s_r       <= '0;
      s_r.lk_st <= BFDSG_RUN;
      s_r.drive <= 1'b1;
      s_r.blank <= 1'b1;
      s_r.demag <= `BFDSG_DEMAG_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign fast_decel_active_out         = s_r.fast;
  assign anti_surge_active_out         = s_r.surge;
  assign brake_current_limit_out       = s_r.cur_lim;
  assign current_clamp_out             = s_r.clamp;
  assign comparator_blanking_out       = s_r.blank;
  assign recirc_brake_out              = s_r.recirc;
  assign demagnetize_window_max_out    = s_r.demag;
  assign drive_enable_out              = s_r.drive;
  assign restart_out                   = s_r.restart;
  assign lock_current_fault_out        = s_r.f_lock;
  assign cycle_current_limit_fault_out = s_r.f_cbc;
  assign rotor_locked_fault_out        = s_r.f_rotor;
  assign sync_lost_fault_out           = s_r.f_sync;
  assign overspeed_fault_out           = s_r.f_ovs;
endmodule : bfdsg_core

// ===== hw/bfdsg_deglitch.sv
// persistence filter: output goes high once the level has been high for the count
// assumes the level input is already synchronous to clk_in
`timescale 1ns/1ps
`include "bfdsg_defs.svh"
module bfdsg_deglitch (
  input  wire logic                    clk_in,
  input  wire logic                    rst_n_in,
  input  wire logic                    level_in,
  input  wire logic [`BFDSG_CNT_W-1:0] count_in,
  output logic                         hit_out
);
  import bfdsg_pkg::*;
  typedef struct packed {
    logic [`BFDSG_CNT_W-1:0] cnt;
    logic                    hit;
  } bfdsg_dg_t;
  bfdsg_dg_t s_r;
  bfdsg_dg_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (!level_in) begin
      s_nxt.cnt = '0;
      s_nxt.hit = 1'b0;
    end else if (s_r.cnt >= count_in) begin
      s_nxt.hit = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + `BFDSG_CNT_W'(1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hit_out = s_r.hit;
endmodule : bfdsg_deglitch

// ===== pkg/bfdsg_defs.svh
// constants for the fast-deceleration and stall-guard block
// assumes duty, speed and current arrive as unsigned fixed-point words on clk_in
`ifndef BFDSG_DEFS_SVH
`define BFDSG_DEFS_SVH
`define BFDSG_DUTY_W        12
`define BFDSG_DUTY_FULL     12'h0_FFF
`define BFDSG_CUR_W         12
`define BFDSG_SPD_W         16
`define BFDSG_CNT_W         24
`define BFDSG_RETRY_W       4
`define BFDSG_DEMAG_W       2
`define BFDSG_DEMAG_RST     2'h0
`define BFDSG_DEMAG_15      2'h2
`define BFDSG_DEMAG_18      2'h1
`define BFDSG_DEMAG_22P5    2'h0
`define BFDSG_RECIR_AUTO_NS 10_000_000
`define BFDSG_CLK_NS        20
`define BFDSG_RECIR_CYC     (`BFDSG_RECIR_AUTO_NS / `BFDSG_CLK_NS)
`define BFDSG_SURGE_DIV     2'h2
`endif

// ===== pkg/bfdsg_pkg.sv
// types shared by the fast-deceleration and stall-guard block
// assumes bfdsg_defs.svh is on the include path
`include "bfdsg_defs.svh"
package bfdsg_pkg;
  typedef enum logic [1:0] {BFDSG_STOP_COAST, BFDSG_STOP_BRAKE, BFDSG_STOP_RECIRC,
                            BFDSG_STOP_RSVD} bfdsg_stop_t;
  typedef enum logic {BFDSG_LOCK_LATCH, BFDSG_LOCK_RETRY} bfdsg_lock_mode_t;
  typedef enum {BFDSG_RUN, BFDSG_LOCKED, BFDSG_WAIT} bfdsg_lock_state_t;
endpackage : bfdsg_pkg

// ===== sim/bfdsg_core_asserts.sv
// timing checks on the ports of the deceleration and stall-guard core
// assumes it is bound to bfdsg_core and the defs header is on the include path
`timescale 1ns/1ps
`include "bfdsg_defs.svh"
module bfdsg_core_asserts (
  input wire logic                      clk_in,
  input wire logic                      rst_n_in,
  input wire logic                      update_in,
  input wire logic                      fast_decel_enable_in,
  input wire logic                      demag_sel_we_in,
  input wire logic                      comparator_blanking_enable_in,
  input wire logic                      cycle_limit_event_in,
  input wire logic                      sync_lost_event_in,
  input wire logic                      fault_clear_in,
  input wire logic                      fast_decel_active_out,
  input wire logic                      comparator_blanking_out,
  input wire logic                      drive_enable_out,
  input wire logic                      restart_out,
  input wire logic                      lock_current_fault_out,
  input wire logic                      cycle_current_limit_fault_out,
  input wire logic                      sync_lost_fault_out,
  input wire logic                      overspeed_fault_out,
  input wire logic [`BFDSG_CUR_W-1:0]   phase_current_in,
  input wire logic [`BFDSG_CUR_W-1:0]   lock_current_threshold_in,
  input wire logic [`BFDSG_CNT_W-1:0]   lock_current_deglitch_in,
  input wire logic [`BFDSG_SPD_W-1:0]   speed_in,
  input wire logic [`BFDSG_SPD_W-1:0]   overspeed_threshold_in,
  input wire logic [`BFDSG_DEMAG_W-1:0] demag_sel_in,
  input wire logic [`BFDSG_DEMAG_W-1:0] demagnetize_window_max_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic [`BFDSG_CNT_W-1:0] over_cnt_r;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || phase_current_in <= lock_current_threshold_in) begin
      over_cnt_r <= '0;
    end else begin
      over_cnt_r <= over_cnt_r + `BFDSG_CNT_W'(1);
    end
  end
  sequence s_resumed;
    drive_enable_out && !lock_current_fault_out;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_lock_deglitch: assert property ($rose(lock_current_fault_out) |->
    over_cnt_r >= lock_current_deglitch_in) else $error("lock flag before deglitch time");
  a_lock_drive_off: assert property ($rose(lock_current_fault_out) |->
    !drive_enable_out) else $error("drive still on at lock");
  a_retry_resume: assert property (restart_out |-> ##[0:1] s_resumed)
    else $error("restart without drive back");
  a_restart_pulse: assert property (restart_out |=> !restart_out)
    else $error("restart longer than one cycle");
  a_fast_disabled: assert property (!fast_decel_enable_in |=> !fast_decel_active_out)
    else $error("fast decel while disabled");
  a_fast_on_update: assert property ($rose(fast_decel_active_out) |-> $past(update_in))
    else $error("fast decel changed off an update");
  a_cycle_sticky: assert property (cycle_limit_event_in |=> cycle_current_limit_fault_out)
    else $error("cycle limit not flagged");
  a_sync_sticky: assert property (sync_lost_event_in |=> sync_lost_fault_out)
    else $error("sync loss not flagged");
  a_fault_hold: assert property (cycle_current_limit_fault_out && !fault_clear_in |=>
    cycle_current_limit_fault_out) else $error("fault flag dropped");
  a_overspeed_set: assert property (speed_in > overspeed_threshold_in |=>
    overspeed_fault_out) else $error("overspeed not flagged");
  a_demag_write: assert property (demag_sel_we_in |=>
    demagnetize_window_max_out == $past(demag_sel_in)) else $error("demag select lost");
  a_blank_follow: assert property ($past(rst_n_in) |->
    comparator_blanking_out == $past(comparator_blanking_enable_in)) else $error("blanking");
endmodule : bfdsg_core_asserts

// ===== sim/bfdsg_motor_model.sv
// motor and power stage seen from the core: phase current follows the load only while driven
// assumes drive_enable_out of the core steers it; the bench sets the load
`timescale 1ns/1ps
module bfdsg_motor_model (
  input  wire logic        clk_in,
  input  wire logic        drive_en_in,
  input  wire logic [11:0] load_in,
  output logic      [11:0] current_out
);
  // one cycle of lag: winding current cannot vanish the instant drive stops
  always_ff @(posedge clk_in) begin
    current_out <= drive_en_in ? load_in : 12'h000;
  end
endmodule : bfdsg_motor_model

// ===== sim/test_bfdsg_core.sv
// self-checking bench for the deceleration and stall-guard core
// assumes the package is compiled first and the defs header is on the include path
`timescale 1ns/1ps
`include "bfdsg_defs.svh"
module test_bfdsg_core;
  import bfdsg_pkg::*;
  logic clk_in = 0, rst_n_in = 0, update_in = 0, fast_decel_enable_in = 0, stop_request_in = 0;
  logic anti_surge_enable_in = 0, speed_scaled_brake_current_enable_in = 0, fault_clear_in = 0;
  logic comparator_blanking_enable_in = 1, demag_sel_we_in = 0;
  logic cycle_limit_event_in = 0, sync_lost_event_in = 0;
  logic [11:0] duty_cmd_in = 0, duty_now_in = 0, slowdown_stop_margin_in = 12'h080;
  logic [11:0] slowdown_duty_threshold_in = 12'hB33, slowdown_min_window_in = 12'h266;
  logic [11:0] quick_slowdown_current_cap_in = 12'h400, zero_speed_brake_current_in = 12'h080;
  logic [11:0] lock_current_threshold_in = 12'h300, load = 0, phase_current_in;
  logic [11:0] brake_current_limit_out;
  logic [15:0] speed_in = 0, speed_max_in = 16'h1000, overspeed_threshold_in = 16'hFFFF;
  logic [23:0] lock_current_deglitch_in = 24'h00_0014, retry_interval_in = 24'h00_001E;
  logic [3:0]  retry_count_in = 4'h2;
  logic [1:0]  demag_sel_in = 0, demagnetize_window_max_out;
  bfdsg_stop_t stop_method_select_in = BFDSG_STOP_COAST;
  bfdsg_lock_mode_t lock_fault_handling_mode_in = BFDSG_LOCK_RETRY;
  logic fast_decel_active_out, anti_surge_active_out, current_clamp_out, restart_out;
  logic comparator_blanking_out, recirc_brake_out, drive_enable_out, lock_current_fault_out;
  logic cycle_current_limit_fault_out, rotor_locked_fault_out, sync_lost_fault_out;
  logic overspeed_fault_out;
  wire logic [2:0] sticky_flags;
  assign sticky_flags = {cycle_current_limit_fault_out, sync_lost_fault_out, overspeed_fault_out};
  int   fails = 0, compares = 0;
  bfdsg_core uut (.clk_in, .rst_n_in, .update_in, .duty_cmd_in, .duty_now_in, .speed_in,
    .speed_max_in, .phase_current_in, .fast_decel_enable_in, .quick_slowdown_current_cap_in,
    .anti_surge_enable_in, .slowdown_stop_margin_in, .speed_scaled_brake_current_enable_in,
    .zero_speed_brake_current_in, .slowdown_duty_threshold_in, .slowdown_min_window_in,
    .comparator_blanking_enable_in, .stop_method_select_in, .stop_request_in,
    .lock_current_threshold_in, .lock_current_deglitch_in, .lock_fault_handling_mode_in,
    .retry_count_in, .retry_interval_in, .demag_sel_we_in, .demag_sel_in,
    .cycle_limit_event_in, .sync_lost_event_in, .overspeed_threshold_in, .fault_clear_in,
    .fast_decel_active_out, .anti_surge_active_out, .brake_current_limit_out,
    .current_clamp_out, .comparator_blanking_out, .recirc_brake_out,
    .demagnetize_window_max_out, .drive_enable_out, .restart_out, .lock_current_fault_out,
    .cycle_current_limit_fault_out, .rotor_locked_fault_out, .sync_lost_fault_out,
    .overspeed_fault_out);
  bfdsg_motor_model u_motor (.clk_in, .drive_en_in(drive_enable_out), .load_in(load),
    .current_out(phase_current_in));
  always #10 clk_in = ~clk_in;
  ////////////////////////////////////////////////////////////////////////////
  task check(input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task complete_run;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  task cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask : cyc
  task automatic wait_hi(ref logic s, input int lim);
    int n;
    for (n = 0; n < lim && s !== 1'b1; n++) cyc(1);
    if (n == lim) begin
      fails++;
      complete_run();
    end
  endtask : wait_hi
  task automatic pulse(ref logic s);
    s = 1;
    cyc(1);
    s = 0;
  endtask : pulse
  // start point is latched on the first update, gating judged on the second
  task t_decel(input logic [11:0] cmd, now0, now1, input logic ef, es, input logic [11:0] el);
    duty_cmd_in = cmd;
    duty_now_in = now0;
    update_in = 1;
    cyc(1);
    duty_now_in = now1;
    cyc(1);
    update_in = 0;
    check(fast_decel_active_out, ef);
    check(anti_surge_active_out, es);
    cyc(1);
    if (ef || es) check(brake_current_limit_out, el);
    check(current_clamp_out, ef && load >= el);
    duty_cmd_in = duty_now_in;
    pulse(update_in);
    cyc(1);
  endtask : t_decel
  task t_lock;
    load = 12'h400;
    cyc(10);
    check(lock_current_fault_out, 0);
    wait_hi(lock_current_fault_out, 40);
    check(rotor_locked_fault_out, 1);
    load = 0;
    wait_hi(restart_out, 80);
    check({drive_enable_out, lock_current_fault_out}, 2'b10);
    lock_fault_handling_mode_in = BFDSG_LOCK_LATCH;
    load = 12'h400;
    wait_hi(lock_current_fault_out, 40);
    load = 0;
    cyc(60);
    check({drive_enable_out, lock_current_fault_out}, 2'b01);
    pulse(fault_clear_in);
    cyc(1);
    check(lock_current_fault_out, 0);
  endtask : t_lock
  task t_faults;
    overspeed_threshold_in = 16'h1100;
    speed_in = 16'h1200;
    cycle_limit_event_in = 1;
    sync_lost_event_in = 1;
    cyc(1);
    {cycle_limit_event_in, sync_lost_event_in, speed_in} = '0;
    cyc(3);
    check(sticky_flags, 3'h7);
    pulse(fault_clear_in);
    cyc(1);
    check(sticky_flags, 3'h0);
  endtask : t_faults
  task t_misc;
    logic [1:0] codes [3];
    codes = '{`BFDSG_DEMAG_15, `BFDSG_DEMAG_18, `BFDSG_DEMAG_22P5};
    demag_sel_we_in = 1;
    foreach (codes[i]) begin
      demag_sel_in = codes[i];
      cyc(1);
      check(demagnetize_window_max_out, codes[i]);
    end
    demag_sel_we_in = 0;
    comparator_blanking_enable_in = 0;
    cyc(2);
    check(comparator_blanking_out, 0);
    stop_request_in = 1;
    cyc(2);
    check(recirc_brake_out, 0);
    stop_method_select_in = BFDSG_STOP_RECIRC;
    cyc(2);
    check(recirc_brake_out, 1);
  endtask : t_misc
  initial begin
    cyc(5);
    rst_n_in = 1;
    cyc(1);
    check({drive_enable_out, comparator_blanking_out, demagnetize_window_max_out}, 4'hC);
    check({lock_current_fault_out, rotor_locked_fault_out, overspeed_fault_out}, 3'h0);
    t_lock();
    fast_decel_enable_in = 1;
    t_decel(12'h100, 12'h800, 12'h7F0, 1, 0, 12'h400);
    t_decel(12'h700, 12'h800, 12'h7F0, 0, 0, 0);
    t_decel(12'h100, 12'h800, 12'h170, 0, 0, 0);
    t_decel(12'h100, 12'hC00, 12'hB00, 0, 0, 0);
    t_decel(12'h100, 12'hC00, 12'h8C0, 1, 0, 12'h400);
    speed_scaled_brake_current_enable_in = 1;
    speed_in = 16'h0800;
    t_decel(12'h100, 12'h800, 12'h7F0, 1, 0, 12'h200);
    speed_in = 0;
    load = 12'h100;
    t_decel(12'h100, 12'h800, 12'h7F0, 1, 0, 12'h080);
    load = 0;
    anti_surge_enable_in = 1;
    t_decel(12'h100, 12'hE00, 12'hDF0, 0, 1, 12'h020);
    fast_decel_enable_in = 0;
    t_decel(12'h100, 12'h800, 12'h7F0, 0, 1, 12'h020);
    t_faults();
    t_misc();
    complete_run();
  end
endmodule : test_bfdsg_core
bind bfdsg_core bfdsg_core_asserts u_chk (.clk_in, .rst_n_in, .update_in,
  .fast_decel_enable_in, .demag_sel_we_in, .comparator_blanking_enable_in,
  .cycle_limit_event_in, .sync_lost_event_in, .fault_clear_in, .fast_decel_active_out,
  .comparator_blanking_out, .drive_enable_out, .restart_out, .lock_current_fault_out,
  .cycle_current_limit_fault_out, .sync_lost_fault_out, .overspeed_fault_out,
  .phase_current_in, .lock_current_threshold_in, .lock_current_deglitch_in, .speed_in,
  .overspeed_threshold_in, .demag_sel_in, .demagnetize_window_max_out);
